/* design/lpec_top.sv */
// Purpose: per-port line performance error counters with AHB-Lite access
// Assumes: framer strobes are one-cycle pulses on SYS_CLK_I
// Notes:   shared second and manual update pins are asynchronous
//
// Behaviour
// - four counters, snapshot on second, 42ms/62.5ms interval or manual.
// - every counter stops at full scale and never wraps.
// - update may follow the shared one-second source or a manual input.
// - count same-polarity mark pairs, skipping B8ZS/HDB3 codewords if on.
// - E1 select bit 1 counts code violations, 0 counts bipolar ones.
// - line code counter ignores sync loss, saturates at 65535.
// - T1 excess zeros add runs of 16 zeros, or 8 with B8ZS.
// - T1 path counts CRC-6 in ESF, Ft (plus Fs optional) in D4.
// - T1 path counter held while receive frame loss is active.
// - E1 path counts CRC-4, held on FAS or CRC-4 sync loss only.
// - path, sync and E-bit counts read as high then low byte.
// - T1 multiframe mode counts out-of-sync multiframes despite frame loss.
// - T1 F-bit mode counts Ft or FPS errors, held in frame loss.
// - E1 sync counter counts FAS word errors unless loss or search.
// - E-bit counter adds one per received E-bit of zero.
// - E-bit counter E1 only, held on FAS or CRC-4 sync loss.
// - each automatic update boundary raises an interrupt.
`timescale 1ns/1ns
`default_nettype none
module lpec_top #(
    parameter int unsigned SEC_CYCLES = lpec_pkg::SEC_CYC,
    parameter int unsigned T1_CYCLES  = lpec_pkg::T1_INTV_CYC,
    parameter int unsigned E1_CYCLES  = lpec_pkg::E1_INTV_CYC
) (
    input  wire logic               SYS_CLK_I,
    input  wire logic               RST_I,
    input  wire logic               CE_I,
    input  wire logic               HSEL_I,
    input  wire logic [31:0]        HADDR_I,
    input  wire logic [1:0]         HTRANS_I,
    input  wire logic               HWRITE_I,
    input  wire logic [2:0]         HSIZE_I,
    input  wire logic [31:0]        HWDATA_I,
    input  wire logic               HREADY_I,
    output var  logic [31:0]        HRDATA_O,
    output var  logic               HREADYOUT_O,
    output var  logic               HRESP_O,
    input  wire lpec_pkg::lpec_frm_t FRM_I,
    input  wire logic               SHARED_SEC_I,
    input  wire logic               MANUAL_UPD_I,
    output var  logic               SEC_TICK_O,
    output var  logic               UPDATE_O,
    output var  logic               IRQ_O
);

    localparam int unsigned TW = lpec_pkg::TMR_W;
    localparam int unsigned CW = lpec_pkg::CNT_W;
    localparam int unsigned NC = lpec_pkg::NUM_CNT;

    // FAS or CRC-4 level alignment missing
    function automatic logic e1_sync_lost(input lpec_pkg::lpec_frm_t f);
        e1_sync_lost = f.receive_frame_loss | f.fas_search | f.crc4_search;
    endfunction

    typedef enum {
        BUS_IDLE,
        BUS_DATA,
        BUS_DONE
    } lpec_bus_st_t;

    lpec_bus_st_t                bus_q;
    logic [lpec_pkg::ADDR_W-1:0] addr_q;
    logic                        wr_q;
    logic                        wsize_ok_q;
    lpec_pkg::lpec_cfg_t         counter_config_q;
    logic [lpec_pkg::INT_W-1:0]  int_stat_q;
    logic [lpec_pkg::INT_W-1:0]  int_mask_q;
    logic [31:0]                 rd_d;
    logic                        wr_stb;
    logic                        sw_upd;
    logic [2:0]                  shr_sync_q;
    logic [2:0]                  man_sync_q;
    logic                        own_sec_tick;
    logic                        intv_tick;
    logic [TW-1:0]               intv_period;
    logic                        upd;
    logic                        auto_upd;
    logic                        last_pol_q;
    logic                        seen_mark_q;
    logic                        last_bpv_pol_q;
    logic                        seen_bpv_q;
    logic [lpec_pkg::RUN_W-1:0]  zero_run_q;
    logic [lpec_pkg::RUN_W-1:0]  zero_thresh;
    logic                        mark;
    logic                        bpv;
    logic                        cv;
    logic                        zero_hit;
    logic [NC-1:0]               evt;
    logic [NC-1:0]               sat;
    logic [CW-1:0]               hold [NC];

    // ==========================================================
    // AHB-Lite slave: one wait state, always OKAY
    always_ff @(posedge SYS_CLK_I)
    begin
        if (RST_I)
        begin
            bus_q      <= BUS_IDLE;
            addr_q     <= '0;
            wr_q       <= 1'b0;
            wsize_ok_q <= 1'b0;
            HRDATA_O   <= '0;
        end
        else if (CE_I)
        begin
            case (bus_q)
                BUS_IDLE, BUS_DONE:
                begin
                    if (HSEL_I && HREADY_I && HTRANS_I[1])
                    begin
                        bus_q      <= BUS_DATA;
                        addr_q     <= HADDR_I[lpec_pkg::ADDR_W-1:0];
                        wr_q       <= HWRITE_I;
                        wsize_ok_q <= (HSIZE_I == lpec_pkg::HSIZE_WORD);
                    end
                    else
                    begin
                        bus_q <= BUS_IDLE;
                    end
                end
                BUS_DATA:
                begin
                    bus_q <= BUS_DONE;
                    if (!wr_q)
                    begin
                        HRDATA_O <= rd_d;
                    end
                end
                default:
                begin
                    bus_q <= BUS_IDLE;
                end
            endcase
        end
    end

    assign HREADYOUT_O = (bus_q != BUS_DATA);
    assign HRESP_O     = 1'b0;
    assign wr_stb      = (bus_q == BUS_DATA) && wr_q && wsize_ok_q;
    assign sw_upd      = wr_stb && (addr_q == lpec_pkg::OFS_COMMAND)
                         && HWDATA_I[lpec_pkg::CMD_MAN_UPD];

    // ==========================================================
    // read multiplexer, unmapped offsets read zero
    always_comb
    begin
        rd_d = '0;
        case (addr_q)
            lpec_pkg::OFS_CONFIG:     rd_d[7:0] = counter_config_q;
            lpec_pkg::OFS_LCV_HI:     rd_d[7:0] = hold[lpec_pkg::CNT_LCV][15:8];
            lpec_pkg::OFS_LCV_LO:     rd_d[7:0] = hold[lpec_pkg::CNT_LCV][7:0];
            lpec_pkg::OFS_PATH_HI:    rd_d[7:0] = hold[lpec_pkg::CNT_PATH][15:8];
            lpec_pkg::OFS_PATH_LO:    rd_d[7:0] = hold[lpec_pkg::CNT_PATH][7:0];
            lpec_pkg::OFS_SYNC_HI:    rd_d[7:0] = hold[lpec_pkg::CNT_SYNC][15:8];
            lpec_pkg::OFS_SYNC_LO:    rd_d[7:0] = hold[lpec_pkg::CNT_SYNC][7:0];
            lpec_pkg::OFS_FEBE_HI:    rd_d[7:0] = hold[lpec_pkg::CNT_FEBE][15:8];
            lpec_pkg::OFS_FEBE_LO:    rd_d[7:0] = hold[lpec_pkg::CNT_FEBE][7:0];
            lpec_pkg::OFS_INT_STATUS: rd_d[lpec_pkg::INT_W-1:0] = int_stat_q;
            lpec_pkg::OFS_INT_MASK:   rd_d[lpec_pkg::INT_W-1:0] = int_mask_q;
            default:                  rd_d = '0;
        endcase
    end

    // ==========================================================
    // control registers
    always_ff @(posedge SYS_CLK_I)
    begin
        if (RST_I)
        begin
            counter_config_q <= lpec_pkg::CFG_RST;
            int_mask_q       <= lpec_pkg::INT_RST;
        end
        else if (CE_I && wr_stb)
        begin
            if (addr_q == lpec_pkg::OFS_CONFIG)
            begin
                counter_config_q <= lpec_pkg::lpec_cfg_t'(HWDATA_I[7:0]);
            end
            if (addr_q == lpec_pkg::OFS_INT_MASK)
            begin
                int_mask_q <= HWDATA_I[lpec_pkg::INT_W-1:0];
            end
        end
    end

    // ==========================================================
    // sticky status, write one to clear, a new event wins
    always_ff @(posedge SYS_CLK_I)
    begin
        if (RST_I)
        begin
            int_stat_q <= lpec_pkg::INT_RST;
        end
        else if (CE_I)
        begin
            int_stat_q[lpec_pkg::INT_UPDATE] <= upd ||
                (int_stat_q[lpec_pkg::INT_UPDATE] && !(wr_stb
                 && addr_q == lpec_pkg::OFS_INT_STATUS
                 && HWDATA_I[lpec_pkg::INT_UPDATE]));
            int_stat_q[lpec_pkg::INT_SAT] <= (|sat) ||
                (int_stat_q[lpec_pkg::INT_SAT] && !(wr_stb
                 && addr_q == lpec_pkg::OFS_INT_STATUS
                 && HWDATA_I[lpec_pkg::INT_SAT]));
        end
    end

    assign IRQ_O = |(int_stat_q & int_mask_q);

    // ==========================================================
    // synchronisers and edge detect for the update pins
    always_ff @(posedge SYS_CLK_I)
    begin
        if (RST_I)
        begin
            shr_sync_q <= '0;
            man_sync_q <= '0;
        end
        else if (CE_I)
        begin
            shr_sync_q <= {shr_sync_q[1:0], SHARED_SEC_I};
            man_sync_q <= {man_sync_q[1:0], MANUAL_UPD_I};
        end
    end

    // ==========================================================
    // update timers and source selection
    assign intv_period = counter_config_q.e1_mode ? TW'(E1_CYCLES)
                                                  : TW'(T1_CYCLES);

    lpec_tick_gen #(
        .W        (TW)
    ) u_sec_tmr (
        .clk_i    (SYS_CLK_I),
        .rst_i    (RST_I),
        .ce_i     (CE_I),
        .period_i (TW'(SEC_CYCLES)),
        .tick_o   (own_sec_tick)
    );

    lpec_tick_gen #(
        .W        (TW)
    ) u_intv_tmr (
        .clk_i    (SYS_CLK_I),
        .rst_i    (RST_I),
        .ce_i     (CE_I),
        .period_i (intv_period),
        .tick_o   (intv_tick)
    );

    always_comb
    begin
        auto_upd = 1'b0;
        upd      = 1'b0;
        case (counter_config_q.upd_src)
            lpec_pkg::UPD_OWN_SEC:
            begin
                auto_upd = own_sec_tick;
                upd      = own_sec_tick;
            end
            lpec_pkg::UPD_INTERVAL:
            begin
                auto_upd = intv_tick;
                upd      = intv_tick;
            end
            lpec_pkg::UPD_SHARED_SEC:
            begin
                upd = shr_sync_q[1] && !shr_sync_q[2];
            end
            lpec_pkg::UPD_MANUAL:
            begin
                upd = sw_upd || (man_sync_q[1] && !man_sync_q[2]);
            end
            default:
            begin
                upd = 1'b0;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK_I)
    begin
        if (RST_I)
        begin
            SEC_TICK_O <= 1'b0;
            UPDATE_O   <= 1'b0;
        end
        else if (CE_I)
        begin
            SEC_TICK_O <= own_sec_tick;
            UPDATE_O   <= auto_upd;
        end
    end

    // ==========================================================
    // line code: polarity history and zero runs
    assign mark = FRM_I.bit_stb && (FRM_I.mark_pos || FRM_I.mark_neg);
    assign bpv  = mark && seen_mark_q && (FRM_I.mark_pos == last_pol_q)
                  && !(counter_config_q.line_code_en && FRM_I.subst);
    assign cv   = bpv && seen_bpv_q
                  && (FRM_I.mark_pos == last_bpv_pol_q);
    assign zero_thresh = counter_config_q.line_code_en
                         ? lpec_pkg::ZERO_RUN_B8ZS
                         : lpec_pkg::ZERO_RUN_AMI;
    assign zero_hit = FRM_I.bit_stb && !mark
                      && (zero_run_q == zero_thresh - 1'b1);

    always_ff @(posedge SYS_CLK_I)
    begin
        if (RST_I)
        begin
            last_pol_q     <= 1'b0;
            seen_mark_q    <= 1'b0;
            last_bpv_pol_q <= 1'b0;
            seen_bpv_q     <= 1'b0;
            zero_run_q     <= '0;
        end
        else if (CE_I && FRM_I.bit_stb)
        begin
            if (mark)
            begin
                last_pol_q  <= FRM_I.mark_pos;
                seen_mark_q <= 1'b1;
                zero_run_q  <= '0;
            end
            else if (zero_run_q != zero_thresh)
            begin
                zero_run_q <= zero_run_q + 1'b1;
            end
            if (bpv)
            begin
                last_bpv_pol_q <= FRM_I.mark_pos;
                seen_bpv_q     <= 1'b1;
            end
        end
    end

    // ==========================================================
    // event selection per counter
    always_comb
    begin
        evt = '0;
        if (counter_config_q.e1_mode)
        begin
            evt[lpec_pkg::CNT_LCV] = counter_config_q.cv_select
                                     ? cv : bpv;
            evt[lpec_pkg::CNT_PATH] = FRM_I.crc_err
                                      && !e1_sync_lost(FRM_I);
            evt[lpec_pkg::CNT_SYNC] = FRM_I.fas_err
                                      && !e1_sync_lost(FRM_I)
                                      && !FRM_I.cas_search;
            evt[lpec_pkg::CNT_FEBE] = FRM_I.ebit_stb && !FRM_I.ebit_val
                                      && !e1_sync_lost(FRM_I);
        end
        else
        begin
            evt[lpec_pkg::CNT_LCV] = bpv || (counter_config_q.cv_select
                                     && zero_hit);
            if (!FRM_I.receive_frame_loss)
            begin
                evt[lpec_pkg::CNT_PATH] = counter_config_q.esf
                    ? FRM_I.crc_err
                    : FRM_I.ft_err || (counter_config_q.count_fs
                                       && FRM_I.fs_err);
            end
            if (counter_config_q.fbit_mode)
            begin
                evt[lpec_pkg::CNT_SYNC] = !FRM_I.receive_frame_loss
                    && (counter_config_q.esf ? FRM_I.fps_err
                                             : FRM_I.ft_err);
            end
            else
            begin
                evt[lpec_pkg::CNT_SYNC] = FRM_I.mf_stb
                                          && FRM_I.sync_oos;
            end
        end
    end

    // ==========================================================
    // the four saturating counters, line code never inhibited
    for (genvar g = 0; g < NC; g++)
    begin : g_cnt
        lpec_sat_cnt #(
            .W      (CW)
        ) u_cnt (
            .clk_i  (SYS_CLK_I),
            .rst_i  (RST_I),
            .ce_i   (CE_I),
            .inc_i  (evt[g]),
            .snap_i (upd),
            .hold_o (hold[g]),
            .sat_o  (sat[g])
        );
    end

endmodule
`default_nettype wire

/* design/lpec_pkg.sv */
// Purpose: shared constants and types of the line performance error counters
// Assumes: 250 MHz system clock, 32-bit AHB-Lite register bus
// Notes:   register offsets are byte addresses, one word per register
package lpec_pkg;

    // ==========================================================
    // register map
    localparam int unsigned ADDR_W          = 8;
    localparam logic [7:0]  OFS_CONFIG      = 8'h00;
    localparam logic [7:0]  OFS_COMMAND     = 8'h04;
    localparam logic [7:0]  OFS_LCV_HI      = 8'h08;
    localparam logic [7:0]  OFS_LCV_LO      = 8'h0C;
    localparam logic [7:0]  OFS_PATH_HI     = 8'h10;
    localparam logic [7:0]  OFS_PATH_LO     = 8'h14;
    localparam logic [7:0]  OFS_SYNC_HI     = 8'h18;
    localparam logic [7:0]  OFS_SYNC_LO     = 8'h1C;
    localparam logic [7:0]  OFS_FEBE_HI     = 8'h20;
    localparam logic [7:0]  OFS_FEBE_LO     = 8'h24;
    localparam logic [7:0]  OFS_INT_STATUS  = 8'h28;
    localparam logic [7:0]  OFS_INT_MASK    = 8'h2C;

    localparam logic [2:0]  HSIZE_WORD      = 3'h2;
    localparam int unsigned CMD_MAN_UPD     = 0;

    // ==========================================================
    // interrupt bits
    localparam int unsigned INT_W           = 2;
    localparam int unsigned INT_UPDATE      = 0;
    localparam int unsigned INT_SAT         = 1;
    localparam logic [1:0]  INT_RST         = 2'h0;

    // ==========================================================
    // counters
    localparam int unsigned CNT_W           = 16;
    localparam int unsigned NUM_CNT         = 4;
    localparam int unsigned CNT_LCV         = 0;
    localparam int unsigned CNT_PATH        = 1;
    localparam int unsigned CNT_SYNC        = 2;
    localparam int unsigned CNT_FEBE        = 3;
    localparam int unsigned RUN_W           = 5;
    localparam logic [4:0]  ZERO_RUN_AMI    = 5'h10;
    localparam logic [4:0]  ZERO_RUN_B8ZS   = 5'h08;

    // ==========================================================
    // update timing
    localparam int unsigned CLK_MHZ         = 250;
    localparam int unsigned SEC_US          = 1000000;
    localparam int unsigned T1_INTV_US      = 42000;
    localparam int unsigned E1_INTV_US      = 62500;
    localparam int unsigned SEC_CYC         = SEC_US * CLK_MHZ;
    localparam int unsigned T1_INTV_CYC     = T1_INTV_US * CLK_MHZ;
    localparam int unsigned E1_INTV_CYC     = E1_INTV_US * CLK_MHZ;
    localparam int unsigned TMR_W           = 28;

    typedef enum logic [1:0] {
        UPD_OWN_SEC,
        UPD_INTERVAL,
        UPD_SHARED_SEC,
        UPD_MANUAL
    } lpec_upd_src_t;

    // counter_config word, bit 0 at the bottom
    typedef struct packed {
        logic          esf;
        logic          line_code_en;
        logic          e1_mode;
        lpec_upd_src_t upd_src;
        logic          count_fs;
        logic          fbit_mode;
        logic          cv_select;
    } lpec_cfg_t;

    localparam lpec_cfg_t CFG_RST = '0;

    // strobes and levels from the receive decoder and framer
    typedef struct packed {
        logic bit_stb;
        logic mark_pos;
        logic mark_neg;
        logic subst;
        logic crc_err;
        logic ft_err;
        logic fs_err;
        logic fps_err;
        logic fas_err;
        logic ebit_stb;
        logic ebit_val;
        logic mf_stb;
        logic sync_oos;
        logic receive_frame_loss;
        logic fas_search;
        logic crc4_search;
        logic cas_search;
    } lpec_frm_t;

endpackage

/* design/lpec_sat_cnt.sv */
// Purpose: saturating event counter with snapshot holding register
// Assumes: inc and snap are one-cycle pulses on the same clock
// Notes:   an event in the snapshot cycle opens the next interval
`timescale 1ns/1ns
`default_nettype none
module lpec_sat_cnt #(
    parameter int unsigned W = 16
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    input  wire logic         inc_i,
    input  wire logic         snap_i,
    output var  logic [W-1:0] hold_o,
    output var  logic         sat_o
);

    localparam logic [W-1:0] MAX_VAL = '1;

    logic [W-1:0] count_q;

    // ==========================================================
    // accumulate, stop at full scale, hand over on snapshot
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            count_q <= '0;
            hold_o  <= '0;
            sat_o   <= 1'b0;
        end
        else if (ce_i)
        begin
            sat_o <= inc_i && !snap_i && (count_q == MAX_VAL - 1'b1);
            if (snap_i)
            begin
                hold_o  <= count_q;
                count_q <= inc_i ? {{(W-1){1'b0}}, 1'b1} : '0;
            end
            else if (inc_i && count_q != MAX_VAL)
            begin
                count_q <= count_q + 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

/* design/lpec_tick_gen.sv */
// Purpose: free-running interval timer giving one pulse per period
// Assumes: period_i at least 1, may change at any time
// Notes:   a shorter new period takes effect at once
`timescale 1ns/1ns
`default_nettype none
module lpec_tick_gen #(
    parameter int unsigned W = 28
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] period_i,
    output var  logic         tick_o
);

    logic [W-1:0] cnt_q;

    // ==========================================================
    // count period_i cycles, pulse on the last one
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt_q  <= '0;
            tick_o <= 1'b0;
        end
        else if (ce_i)
        begin
            if (cnt_q >= period_i - 1'b1)
            begin
                cnt_q  <= '0;
                tick_o <= 1'b1;
            end
            else
            begin
                cnt_q  <= cnt_q + 1'b1;
                tick_o <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

/* tb/lpec_frm_model.sv */
// Purpose: receive framer stand-in feeding the counter block
// Assumes: bench sets the wanted strobes and levels
// Notes:   unqualified data lines carry a toggling pattern
`timescale 1ns/1ns
`default_nettype none
module lpec_frm_model (
    input  wire logic                 clk_i,
    input  wire lpec_pkg::lpec_frm_t  want_i,
    output var  lpec_pkg::lpec_frm_t  frm_o
);
    logic junk_q = 1'h0;
    always_ff @(posedge clk_i)
    begin
        junk_q <= !junk_q;
    end
    always_comb
    begin
        frm_o = want_i;
        if (!want_i.bit_stb)
        begin
            frm_o.mark_pos = junk_q;
            frm_o.mark_neg = !junk_q;
            frm_o.subst    = junk_q;
        end
        if (!want_i.ebit_stb)
            frm_o.ebit_val = junk_q;
    end
endmodule
`default_nettype wire

/* tb/lpec_top_chk.sv */
// Purpose: port checks of the error counter block
// Assumes: one slave, hready fed back
// Notes:   bound below the module
`timescale 1ns/1ns
`default_nettype none
module lpec_top_chk (
    input wire logic        SYS_CLK_I,
    input wire logic        RST_I,
    input wire logic        CE_I,
    input wire logic        HSEL_I,
    input wire logic [1:0]  HTRANS_I,
    input wire logic        HREADY_I,
    input wire logic [31:0] HRDATA_O,
    input wire logic        HREADYOUT_O,
    input wire logic        HRESP_O,
    input wire logic        SEC_TICK_O,
    input wire logic        UPDATE_O
);
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);
    sequence s_taken;
        HSEL_I && HREADY_I && HTRANS_I[1] && CE_I;
    endsequence
    sequence s_wait;
        !HREADYOUT_O ##1 HREADYOUT_O;
    endsequence
    a_resp_okay: assert property (!HRESP_O)
        else $error("response not okay");
    a_one_wait: assert property (s_taken |=> s_wait)
        else $error("wait state missing");
    a_wait_ends: assert property (!HREADYOUT_O |=> HREADYOUT_O)
        else $error("wait state too long");
    a_no_stall: assert property ($fell(HREADYOUT_O) |->
        $past(HSEL_I && HREADY_I && HTRANS_I[1]))
        else $error("stall without transfer");
    a_rdata_hold: assert property (HREADYOUT_O && $past(HREADYOUT_O) |->
        $stable(HRDATA_O)) else $error("read data moved");
    a_upd_pulse: assert property (UPDATE_O |=> !UPDATE_O)
        else $error("update pulse too long");
    a_tick_pulse: assert property (SEC_TICK_O |=> !SEC_TICK_O)
        else $error("tick pulse too long");
    a_tick_gap: assert property (SEC_TICK_O |=> !SEC_TICK_O [*8])
        else $error("ticks too close");
endmodule
bind lpec_top lpec_top_chk u_chk (.SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I),
    .CE_I(CE_I), .HSEL_I(HSEL_I), .HTRANS_I(HTRANS_I), .HREADY_I(HREADY_I),
    .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
    .SEC_TICK_O(SEC_TICK_O), .UPDATE_O(UPDATE_O));
`default_nettype wire

/* tb/lpec_top_test.sv */
// Purpose: self-checking bench of the error counter block
// Assumes: manual update mode gives exact counts
// Notes:   short timer periods via parameters
`timescale 1ns/1ns
`default_nettype none
module lpec_top_test;
    logic                clk = 1'h0;
    logic                rst = 1'h1;
    logic                sel = 1'h0;
    logic                wr = 1'h0;
    logic [1:0]          tr = 2'h0;
    logic [31:0]         ad = 32'h0;
    logic [31:0]         wd = 32'h0;
    logic [31:0]         rd;
    logic                rdy, upd, irq;
    logic                mu = 1'h0;
    lpec_pkg::lpec_frm_t want = '0;
    lpec_pkg::lpec_frm_t frm;
    int                  n_fail = 0;
    int                  n_checks = 0;
    int                  cyc = 0;
    initial forever #2 clk = !clk;
    lpec_frm_model u_frm (.clk_i(clk), .want_i(want), .frm_o(frm));
    lpec_top #(.SEC_CYCLES(40), .T1_CYCLES(8), .E1_CYCLES(12)) dut (
        .SYS_CLK_I(clk), .RST_I(rst), .CE_I(1'h1), .HSEL_I(sel),
        .HADDR_I(ad), .HTRANS_I(tr), .HWRITE_I(wr), .HWDATA_I(wd),
        .HSIZE_I(lpec_pkg::HSIZE_WORD), .HREADY_I(rdy), .HRDATA_O(rd),
        .HREADYOUT_O(rdy), .HRESP_O(), .FRM_I(frm), .SHARED_SEC_I(1'h0),
        .MANUAL_UPD_I(mu), .SEC_TICK_O(), .UPDATE_O(upd), .IRQ_O(irq));
    task finish_test;
        $display("checks %0d errors %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 90000)
        begin
            n_fail++;
            finish_test();
        end
    end
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e)
        begin
            n_fail++;
            $display("Error at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        sel <= 1'h1;
        tr <= 2'h2;
        ad <= {24'h0, a};
        wr <= w;
        do @(posedge clk); while (rdy !== 1'h1);
        sel <= 1'h0;
        tr <= 2'h0;
        wd <= d;
        do @(posedge clk); while (rdy !== 1'h1);
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] e);
        xfer(a, 1'h0, 32'h0);
        chk(rd, e);
    endtask
    task snap;
        xfer(lpec_pkg::OFS_COMMAND, 1'h1, 32'h1);
        repeat (3) @(posedge clk);
    endtask
    task ev(input lpec_pkg::lpec_frm_t f, input int n);
        @(posedge clk);
        want <= f;
        repeat (n) @(posedge clk);
        want <= '0;
    endtask
    task t_path;
        xfer(lpec_pkg::OFS_CONFIG, 1'h1, 32'h98);
        snap();
        ev('{crc_err: 1'h1, default: 1'h0}, 3);
        snap();
        rchk(lpec_pkg::OFS_PATH_LO, 32'h3);
        rchk(lpec_pkg::OFS_PATH_HI, 32'h0);
        ev('{crc_err: 1'h1, receive_frame_loss: 1'h1, mf_stb: 1'h1,
            sync_oos: 1'h1, default: 1'h0}, 4);
        snap();
        rchk(lpec_pkg::OFS_PATH_LO, 32'h0);
        rchk(lpec_pkg::OFS_SYNC_LO, 32'h4);
    endtask
    task t_irq;
        xfer(lpec_pkg::OFS_INT_MASK, 1'h1, 32'h1);
        xfer(lpec_pkg::OFS_INT_STATUS, 1'h1, 32'h3);
        chk({31'h0, irq}, 32'h0);
        xfer(lpec_pkg::OFS_CONFIG, 1'h1, 32'h08);
        @(posedge clk iff upd);
        @(posedge clk);
        chk({31'h0, irq}, 32'h1);
    endtask
    task t_line;
        xfer(lpec_pkg::OFS_CONFIG, 1'h1, 32'h18);
        snap();
        ev('{bit_stb: 1'h1, mark_pos: 1'h1, default: 1'h0}, 2);
        ev('{bit_stb: 1'h1, mark_neg: 1'h1, default: 1'h0}, 2);
        snap();
        rchk(lpec_pkg::OFS_LCV_LO, 32'h2);
        xfer(lpec_pkg::OFS_CONFIG, 1'h1, 32'h19);
        ev('{bit_stb: 1'h1, mark_pos: 1'h1, default: 1'h0}, 1);
        snap();
        ev('{bit_stb: 1'h1, default: 1'h0}, 16);
        snap();
        rchk(lpec_pkg::OFS_LCV_LO, 32'h1);
    endtask
    task t_e1;
        xfer(lpec_pkg::OFS_CONFIG, 1'h1, 32'h38);
        snap();
        ev('{ebit_stb: 1'h1, default: 1'h0}, 2);
        ev('{ebit_stb: 1'h1, ebit_val: 1'h1, default: 1'h0}, 1);
        ev('{ebit_stb: 1'h1, fas_search: 1'h1, default: 1'h0}, 3);
        ev('{crc_err: 1'h1, cas_search: 1'h1, default: 1'h0}, 2);
        ev('{fas_err: 1'h1, default: 1'h0}, 2);
        ev('{fas_err: 1'h1, cas_search: 1'h1, default: 1'h0}, 1);
        mu <= 1'h1;
        repeat (4) @(posedge clk);
        mu <= 1'h0;
        rchk(lpec_pkg::OFS_FEBE_LO, 32'h2);
        rchk(lpec_pkg::OFS_PATH_LO, 32'h2);
        rchk(lpec_pkg::OFS_SYNC_LO, 32'h2);
    endtask
    task t_sat;
        xfer(lpec_pkg::OFS_CONFIG, 1'h1, 32'h18);
        ev('{bit_stb: 1'h1, mark_pos: 1'h1, receive_frame_loss: 1'h1,
            default: 1'h0}, 65540);
        snap();
        rchk(lpec_pkg::OFS_LCV_HI, 32'hFF);
        rchk(lpec_pkg::OFS_LCV_LO, 32'hFF);
        rchk(lpec_pkg::OFS_INT_STATUS, 32'h3);
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        rchk(lpec_pkg::OFS_INT_MASK, 32'h0);
        rchk(8'h30, 32'h0);
        t_path();
        t_irq();
        t_line();
        t_e1();
        t_sat();
        finish_test();
    end
endmodule
`default_nettype wire
